// ===== src/ufn_pkg.sv
package ufn_pkg;
    // Command codes on the shared microprocessor bus
    localparam logic [7:0]  UFN_CMD_FRAME_COUNT_RD = 8'h0f;
    localparam logic [7:0]  UFN_CMD_LS_THRESH_RD   = 8'h11;
    localparam logic [7:0]  UFN_CMD_LS_THRESH_WR   = 8'h91;
    // Field layout
    localparam int          UFN_FN_W               = 16;
    localparam int          UFN_LST_W              = 11;
    localparam int          UFN_FR_W               = 14;
    localparam int          UFN_DATA_W             = 32;
    // Reset values
    localparam logic [15:0] UFN_FN_RST             = 16'h0000;
    localparam logic [10:0] UFN_LST_RST            = 11'h628;
    localparam logic [13:0] UFN_FI_RST             = 14'h2edf;
    // One full-speed bit time is 1/12 MHz; clock is 40 MHz
    localparam int          UFN_CLK_HZ             = 40000000;
    localparam int          UFN_BIT_HZ             = 12000000;
    localparam int          UFN_BIT_CYC_MAX        = UFN_CLK_HZ / UFN_BIT_HZ;
    // Bit-time accumulator step: fractional divider keeps mean rate exact
    localparam logic [25:0] UFN_BIT_STEP           = 26'(UFN_BIT_HZ);
    localparam logic [25:0] UFN_BIT_WRAP           = 26'(UFN_CLK_HZ);

    typedef enum logic [1:0] {
        UFN_ST_RESET       = 2'b00,
        UFN_ST_OPERATIONAL = 2'b01,
        UFN_ST_SUSPEND     = 2'b10
    } ufn_hc_state_t;
endpackage

// ===== src/ufn_tick_if.sv
`timescale 1ns/1ps
interface ufn_tick_if;
    logic bit_tick;
    modport src (output bit_tick);
    modport dst (input  bit_tick);
endinterface

// ===== src/ufn_bit_tick.sv
`timescale 1ns/1ps
module ufn_bit_tick
    import ufn_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    ufn_tick_if.src   tick
);
    logic [25:0] acc_q;
    logic [26:0] sum;

    // Fractional accumulator: 12 ticks per 40 clocks with no long-term drift
    assign sum           = {1'b0, acc_q} + {1'b0, UFN_BIT_STEP};
    assign tick.bit_tick = (sum >= {1'b0, UFN_BIT_WRAP});

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_q <= 26'h0000000;
        end else if (tick.bit_tick) begin
            acc_q <= 26'(sum - {1'b0, UFN_BIT_WRAP});
        end else begin
            acc_q <= sum[25:0];
        end
    end
endmodule // ufn_bit_tick

// ===== src/ufn_frame_timer.sv
`timescale 1ns/1ps
// What this block does
// [R1] Keep a 16-bit frame count
// [R2] Increment frame count on remaining-counter reload
// [R3] Frame count wraps from ffff to zero
// [R4] Increment automatically on entering running state
// [R5] Set frame-begin flag whenever count advances
// [R6] Frame count read-only via code 0f
// [R7] Software may extend count to 32 bits
// [R8] Hold 11-bit low-speed start threshold
// [R9] Start low-speed only if remaining >= threshold
// [R10] Threshold resets to 1576
// [R11] Threshold read code 11, write 91
// [R12] Software computes threshold including overhead
// [R13] Threshold not altered once established
// [R14] Remaining counter decrements per bit, reloads
// [R15] Frame length defaults to 11999 bits; here it is taken from frame_length_bits_i, with no default
// [R16] Count clears on reset; reserved bits zero
// [R17] Writes to reserved threshold bits ignored
module ufn_frame_timer
    import ufn_pkg::*;
(
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_n_i,
    input  wire ufn_pkg::ufn_hc_state_t hc_state_i,
    input  wire logic [13:0]           frame_length_bits_i,
    input  wire logic                  cmd_valid_i,
    input  wire logic [7:0]            cmd_code_i,
    input  wire logic [31:0]           cmd_wdata_i,
    output logic      [31:0]           cmd_rdata_o,
    output logic                       cmd_hit_o,
    input  wire logic                  frame_begin_flag_clr_i,
    output logic                       frame_begin_flag_o,
    output logic      [13:0]           frame_bits_left_o,
    output logic                       frame_tick_o,
    input  wire logic                  ls_req_i,
    output logic                       ls_start_ok_o
);
    import ufn_pkg::*;

    ufn_tick_if    tick_if ();
    ufn_hc_state_t state_prev_q;
    logic [15:0]   frame_count_field_q;
    logic [10:0]   slow_start_limit_q;
    logic [13:0]   frame_bits_left_q;
    logic [31:0]   rdata_q;
    logic          frame_begin_flag_q;
    logic          enter_run;
    logic          reload;
    logic          advance;
    logic          is_run;

    ufn_bit_tick u_bit_tick (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .tick       (tick_if.src)
    );

    assign is_run    = (hc_state_i == UFN_ST_OPERATIONAL);
    assign enter_run = is_run && (state_prev_q != UFN_ST_OPERATIONAL);
    // Reload happens on the bit boundary after the counter sits at zero
    assign reload    = is_run && tick_if.bit_tick && (frame_bits_left_q == 14'h0000); // [R14]
    assign advance   = enter_run || reload; // [R2] [R4]

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_prev_q <= UFN_ST_RESET;
        end else begin
            state_prev_q <= hc_state_i;
        end
    end

    // Remaining bit times; entering the running state loads the frame length
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_bits_left_q <= 14'h0000;
        end else if (enter_run || reload) begin
            frame_bits_left_q <= frame_length_bits_i; // [R14] [R15]
        end else if (is_run && tick_if.bit_tick) begin
            frame_bits_left_q <= frame_bits_left_q - 14'h0001; // [R14]
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_count_field_q <= UFN_FN_RST; // [R16]
        end else if (advance) begin
            frame_count_field_q <= frame_count_field_q + 16'h0001; // [R1] [R3]
        end
    end

    // Set wins over a clear arriving in the same cycle
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_begin_flag_q <= 1'b0;
        end else if (advance) begin
            frame_begin_flag_q <= 1'b1; // [R5]
        end else if (frame_begin_flag_clr_i) begin
            frame_begin_flag_q <= 1'b0;
        end
    end

    // Only the documented write code reaches the threshold; no hardware path alters it
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slow_start_limit_q <= UFN_LST_RST; // [R10]
        end else if (cmd_valid_i && cmd_code_i == UFN_CMD_LS_THRESH_WR) begin
            slow_start_limit_q <= cmd_wdata_i[UFN_LST_W-1:0]; // [R8] [R11] [R13] [R17]
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h00000000;
        end else if (cmd_valid_i && cmd_code_i == UFN_CMD_FRAME_COUNT_RD) begin
            rdata_q <= {16'h0000, frame_count_field_q}; // [R6] [R16]
        end else if (cmd_valid_i && cmd_code_i == UFN_CMD_LS_THRESH_RD) begin
            rdata_q <= {21'h000000, slow_start_limit_q}; // [R11] [R16]
        end
    end

    assign cmd_hit_o = cmd_valid_i && (cmd_code_i == UFN_CMD_FRAME_COUNT_RD
                                    || cmd_code_i == UFN_CMD_LS_THRESH_RD
                                    || cmd_code_i == UFN_CMD_LS_THRESH_WR);
    assign cmd_rdata_o        = rdata_q;
    assign frame_begin_flag_o = frame_begin_flag_q;
    assign frame_bits_left_o  = frame_bits_left_q;
    assign frame_tick_o       = advance;
    assign ls_start_ok_o      = ls_req_i && is_run
                                && ({3'b000, slow_start_limit_q} <= frame_bits_left_q); // [R9]

    // Every advance moves the count by exactly one
    property p_fn_inc;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        advance |=> frame_count_field_q == $past(frame_count_field_q) + 16'h0001;
    endproperty
    a_fn_inc: assert property (p_fn_inc) // [R2]
        else $error("frame count did not advance");

    // Count is a pure event counter; nothing else may touch it
    property p_fn_hold;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !advance |=> $stable(frame_count_field_q);
    endproperty
    a_fn_hold: assert property (p_fn_hold) // [R1]
        else $error("frame count moved without reload");

    // Wrap is checked apart, the increment check hides it in modulo arithmetic
    property p_fn_wrap;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (advance && frame_count_field_q == 16'hffff) |=> frame_count_field_q == 16'h0000;
    endproperty
    a_fn_wrap: assert property (p_fn_wrap) // [R3]
        else $error("frame count did not wrap");

    // Entry alone must be enough to move the count
    property p_enter;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        enter_run |=> frame_count_field_q != $past(frame_count_field_q);
    endproperty
    a_enter: assert property (p_enter) // [R4]
        else $error("no increment on entering running state");

    // Entry also restarts the frame from the full length
    property p_enter_load;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        enter_run |=> frame_bits_left_q == $past(frame_length_bits_i);
    endproperty
    a_enter_load: assert property (p_enter_load) // [R4]
        else $error("frame length not loaded on entry");

    // Set must win even when software clears in the same cycle
    property p_flag;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        advance |=> frame_begin_flag_q;
    endproperty
    a_flag: assert property (p_flag) // [R5]
        else $error("frame begin flag not set");

    // A lone clear drops the flag on the next edge
    property p_flag_clr;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (frame_begin_flag_clr_i && !advance) |=> !frame_begin_flag_q;
    endproperty
    a_flag_clr: assert property (p_flag_clr) // [R5]
        else $error("frame begin flag not cleared");

    // Sticky: without set or clear the flag keeps its value
    property p_flag_hold;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (!advance && !frame_begin_flag_clr_i) |=> $stable(frame_begin_flag_q);
    endproperty
    a_flag_hold: assert property (p_flag_hold) // [R5]
        else $error("frame begin flag changed by itself");

    // Read returns the count as it stood when the code was taken
    property p_rd_fn;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (cmd_valid_i && cmd_code_i == UFN_CMD_FRAME_COUNT_RD) |=> cmd_rdata_o == {16'h0000, $past(frame_count_field_q)};
    endproperty
    a_rd_fn: assert property (p_rd_fn) // [R6]
        else $error("frame count read wrong");

    // Upper half of the count word is reserved
    property p_fn_rsvd;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (cmd_valid_i && cmd_code_i == UFN_CMD_FRAME_COUNT_RD) |=> cmd_rdata_o[31:16] == 16'h0000;
    endproperty
    a_fn_rsvd: assert property (p_fn_rsvd) // [R16]
        else $error("reserved count bits not zero");

    // Read data holds until the next read code
    property p_rdata_hold;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !(cmd_valid_i && (cmd_code_i == UFN_CMD_FRAME_COUNT_RD || cmd_code_i == UFN_CMD_LS_THRESH_RD))
            |=> $stable(cmd_rdata_o);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) // [R6]
        else $error("read data changed without a read");

    // Unknown codes, including writes to the count, are refused
    property p_hit_unknown;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (cmd_code_i != UFN_CMD_FRAME_COUNT_RD && cmd_code_i != UFN_CMD_LS_THRESH_RD
            && cmd_code_i != UFN_CMD_LS_THRESH_WR) |-> !cmd_hit_o;
    endproperty
    a_hit_unknown: assert property (p_hit_unknown) // [R6]
        else $error("unknown code accepted");

    // Both threshold codes are accepted with the strobe
    property p_hit_known;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (cmd_valid_i && (cmd_code_i == UFN_CMD_LS_THRESH_RD || cmd_code_i == UFN_CMD_LS_THRESH_WR)) |-> cmd_hit_o;
    endproperty
    a_hit_known: assert property (p_hit_known) // [R11]
        else $error("threshold code not accepted");

    // Write code loads the low eleven bits
    property p_lst_wr;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (cmd_valid_i && cmd_code_i == UFN_CMD_LS_THRESH_WR) |=> slow_start_limit_q == $past(cmd_wdata_i[10:0]);
    endproperty
    a_lst_wr: assert property (p_lst_wr) // [R11]
        else $error("threshold write not taken");

    // Threshold read returns the stored value
    property p_rd_lst;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (cmd_valid_i && cmd_code_i == UFN_CMD_LS_THRESH_RD) |=> cmd_rdata_o[10:0] == $past(slow_start_limit_q);
    endproperty
    a_rd_lst: assert property (p_rd_lst) // [R8]
        else $error("threshold read wrong");

    // Too little frame left: no low-speed start
    property p_ls_cmp;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (ls_req_i && is_run && frame_bits_left_q < {3'b000, slow_start_limit_q}) |-> !ls_start_ok_o;
    endproperty
    a_ls_cmp: assert property (p_ls_cmp) // [R9]
        else $error("low-speed start past threshold");

    // Equal counts as enough; an off-by-one here would waste the last slot
    property p_ls_ok;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (ls_req_i && is_run && frame_bits_left_q >= {3'b000, slow_start_limit_q}) |-> ls_start_ok_o;
    endproperty
    a_ls_ok: assert property (p_ls_ok) // [R9]
        else $error("low-speed start refused with time left");

    // Outside the running state nothing may be started
    property p_ls_off;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !is_run |-> !ls_start_ok_o;
    endproperty
    a_ls_off: assert property (p_ls_off) // [R9]
        else $error("low-speed start while not running");

    // Only the write code may alter the threshold
    property p_lst_keep;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !(cmd_valid_i && cmd_code_i == UFN_CMD_LS_THRESH_WR) |=> $stable(slow_start_limit_q);
    endproperty
    a_lst_keep: assert property (p_lst_keep) // [R13]
        else $error("threshold changed without write");

    // One step down per bit time inside a frame
    property p_fr_dec;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (is_run && !enter_run && tick_if.bit_tick && frame_bits_left_q != 14'h0000) |=>
            frame_bits_left_q == $past(frame_bits_left_q) - 14'h0001;
    endproperty
    a_fr_dec: assert property (p_fr_dec) // [R14]
        else $error("remaining count did not decrement");

    // Zero is held for one bit time, then the full length comes back
    property p_reload;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        reload |=> frame_bits_left_q == $past(frame_length_bits_i);
    endproperty
    a_reload: assert property (p_reload) // [R14]
        else $error("remaining count not reloaded");

    // Counter freezes outside the running state
    property p_fr_hold;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !is_run |=> $stable(frame_bits_left_q);
    endproperty
    a_fr_hold: assert property (p_fr_hold) // [R14]
        else $error("remaining count moved while halted");

    // Reserved threshold bits never leak back out
    property p_lst_rd;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (cmd_valid_i && cmd_code_i == UFN_CMD_LS_THRESH_RD) |=> cmd_rdata_o[31:11] == 21'h000000;
    endproperty
    a_lst_rd: assert property (p_lst_rd) // [R17]
        else $error("reserved threshold bits not zero");
endmodule // ufn_frame_timer

// ===== verification/ufn_frame_timer_bench.sv
`timescale 1ns/1ps
module ufn_frame_timer_bench;
    import ufn_pkg::*;
    logic          clk;
    logic          rst_n;
    logic          vld;
    logic          clr;
    logic          req;
    logic          hit;
    logic          flag;
    logic          tick;
    logic          ok;
    logic          after_tick;
    ufn_hc_state_t st;
    ufn_hc_state_t st_prev;
    logic [13:0]   flen;
    logic [13:0]   left;
    logic [7:0]    code;
    logic [31:0]   wdata;
    logic [31:0]   rdata;
    logic [31:0]   d;
    int            fails;
    int            samples_checked;
    int            seed;
    int            fn_m;
    int            thr_m;
    int            cyc;
    int            acc_m;
    int            left_m;
    logic          btick_m;
    logic          tick_m;
    logic          run_m;

    ufn_frame_timer uut (.core_clk_i(clk), .rst_n_i(rst_n), .hc_state_i(st), .frame_length_bits_i(flen),
        .cmd_valid_i(vld), .cmd_code_i(code), .cmd_wdata_i(wdata), .cmd_rdata_o(rdata), .cmd_hit_o(hit),
        .frame_begin_flag_clr_i(clr), .frame_begin_flag_o(flag), .frame_bits_left_o(left),
        .frame_tick_o(tick), .ls_req_i(req), .ls_start_ok_o(ok));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmd(logic [7:0] c, logic [31:0] dat, logic known);
        @(posedge clk);
        vld <= 1'b1;
        code <= c;
        wdata <= dat;
        #1 chk("cmd_hit", 32'(known), 32'(hit));
        @(posedge clk);
        vld <= 1'b0;
        #1;
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Own bit-time, frame and count model; reads are done only while halted
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rst_n) begin
            btick_m = (acc_m + UFN_BIT_HZ >= UFN_CLK_HZ);
            acc_m = btick_m ? acc_m + UFN_BIT_HZ - UFN_CLK_HZ : acc_m + UFN_BIT_HZ;
            run_m = (st == UFN_ST_OPERATIONAL);
            tick_m = (run_m && st_prev != UFN_ST_OPERATIONAL) || (run_m && btick_m && left_m == 0);
            chk("bits_left", 32'(left_m), 32'(left));
            chk("frame_tick", 32'(tick_m), 32'(tick));
            if (after_tick) chk("reload", 32'(flen), 32'(left));
            if (st == UFN_ST_OPERATIONAL && st_prev != UFN_ST_OPERATIONAL) chk("entry_tick", 1, 32'(tick));
            chk("ls_ok", 32'(req && run_m && left_m >= thr_m), 32'(ok));
            if (tick_m) begin
                fn_m = fn_m + 1;
                left_m = int'(flen);
            end else if (run_m && btick_m) begin
                left_m = left_m - 1;
            end
            after_tick <= tick;
            st_prev <= st;
            req <= 1'($random(seed));
        end
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        seed = 39853;
        {rst_n, vld, clr, req, after_tick, code, wdata} = '0;
        st = UFN_ST_RESET;
        st_prev = UFN_ST_RESET;
        flen = 14'd20 + 14'($random(seed) & 15);
        {fn_m, cyc, fails, samples_checked, acc_m, left_m} = '0;
        thr_m = 1576;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        cmd(UFN_CMD_FRAME_COUNT_RD, 32'h0, 1'b1);
        chk("count_reset", 32'h0, rdata);
        cmd(UFN_CMD_LS_THRESH_RD, 32'h0, 1'b1);
        chk("thr_reset", 32'h628, rdata);
        cmd(8'h8f, 32'h0, 1'b0);
        chk("flag_reset", 32'h0, 32'(flag));
        for (int i = 0; i < 4; i++) begin
            thr_m = {1'b0, 31'($random(seed))} % (int'(flen) + 4);
            d = {21'($random(seed)), 11'(thr_m)};
            cmd(UFN_CMD_LS_THRESH_WR, d, 1'b1);
            cmd(UFN_CMD_LS_THRESH_RD, 32'h0, 1'b1);
            chk("thr", 32'(thr_m), rdata);
            @(posedge clk);
            st <= UFN_ST_OPERATIONAL;
            repeat (200) @(posedge clk);
            st <= i[0] ? UFN_ST_SUSPEND : UFN_ST_RESET;
            repeat (2) @(posedge clk);
            #1 chk("flag_set", 32'h1, 32'(flag));
            @(posedge clk);
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            #1 chk("flag_clr", 32'h0, 32'(flag));
            cmd(UFN_CMD_FRAME_COUNT_RD, 32'h0, 1'b1);
            chk("count", 32'(fn_m & 32'hffff), rdata);
            $display("test %0d done", i);
        end
        final_report();
    end
endmodule // ufn_frame_timer_bench
